/* File: include/dsp_bank_pkg.sv */
package dsp_bank_pkg;

    // serial bus identity bytes
    localparam logic [7:0] ID_WRITE = 8'h60;
    localparam logic [7:0] ID_READ = 8'h61;

    // bank page register and the value that exposes this bank
    localparam logic [7:0] PAGE_ADDR = 8'hFF;
    localparam logic [7:0] PAGE_THIS = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;

    // indirect effects port
    localparam logic [7:0] FX_DATA_ADDR = 8'h7D;
    localparam int FX_AW = 4;
    localparam int FX_DEPTH = 16;

    // directly mapped registers, entry index order
    localparam int NREG = 21;
    localparam int IX_BYPASS = 0;
    localparam int IX_QSCALE = 1;
    localparam int IX_DIVIDER = 2;
    localparam int IX_WIN_W = 3;
    localparam int IX_WIN_H = 4;
    localparam int IX_XOFF = 5;
    localparam int IX_YOFF = 6;
    localparam int IX_WIN_HIGH = 7;
    localparam int IX_DPATH = 8;
    localparam int IX_WIN_MSB = 9;
    localparam int IX_ZOOM_W = 10;
    localparam int IX_ZOOM_H = 11;
    localparam int IX_ZOOM_HI = 12;
    localparam int IX_FX_INDEX = 13;
    localparam int IX_ENABLE_B = 14;
    localparam int IX_ENABLE_C = 15;
    localparam int IX_SIZE_LOW = 16;
    localparam int IX_IMG_W = 17;
    localparam int IX_IMG_H = 18;
    localparam int IX_ENABLE_MAIN = 19;
    localparam int IX_ENABLE_PIPE = 20;

    localparam logic [NREG-1:0][7:0] REG_ADDR = {
        8'hC3, 8'hC2, 8'hC1, 8'hC0, 8'h8C, 8'h87, 8'h86,
        8'h7C, 8'h5C, 8'h5B, 8'h5A, 8'h57, 8'h56, 8'h55,
        8'h54, 8'h53, 8'h52, 8'h51, 8'h50, 8'h44, 8'h05};
    localparam logic [NREG-1:0][7:0] REG_RST = {
        8'hFF, 8'h0C, 8'h60, 8'h80, 8'h00, 8'h50, 8'h0D,
        8'h00, 8'h00, 8'h48, 8'h58, 8'h00, 8'h00, 8'h08,
        8'h00, 8'h00, 8'hF0, 8'h40, 8'h00, 8'h0C, 8'h01};

    // field layouts
    typedef struct packed {
        logic low_power_datapath;
        logic round_enable;
        logic [2:0] v_divider;
        logic [2:0] h_divider;
    } divider_reg_t;

    typedef struct packed {
        logic height_b8;
        logic [2:0] yoff_hi;
        logic width_b8;
        logic [2:0] xoff_hi;
    } window_hi_reg_t;

    typedef struct packed {
        logic [3:0] zoom_rate;
        logic rsvd;
        logic height_b8;
        logic [1:0] width_hi;
    } zoom_hi_reg_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic downscale_enable;
        logic special_effects;
        logic chroma_adjust_enable;
        logic chroma_average_enable;
        logic rsvd1;
        logic colour_matrix_enable;
    } enable_b_reg_t;

    typedef struct packed {
        logic black_pixel_fix_enable;
        logic white_pixel_fix_enable;
        logic [5:0] rsvd;
    } enable_c_reg_t;

    typedef struct packed {
        logic rsvd;
        logic width_b11;
        logic [2:0] width_lo;
        logic [2:0] height_lo;
    } size_low_reg_t;

    typedef struct packed {
        logic exposure_ctrl_enable;
        logic exposure_ctrl_select;
        logic stats_select;
        logic vertical_first;
        logic chroma_422_select;
        logic luma_chroma_path_enable;
        logic rgb_path_enable;
        logic raw_path_enable;
    } enable_main_reg_t;

    typedef struct packed {
        logic colour_interp_enable;
        logic dummy_enable;
        logic raw_gamma_enable;
        logic digital_gain_enable;
        logic white_balance_enable;
        logic white_balance_gain_enable;
        logic lens_correction_enable;
        logic preprocess_enable;
    } enable_pipe_reg_t;

    // decoded controls handed to the image pipe
    typedef struct packed {
        logic bypass_dsp;
        logic [7:0] quant_scale;
        divider_reg_t divider;
        logic [9:0] window_width;
        logic [8:0] window_height;
        logic [10:0] x_offset;
        logic [10:0] y_offset;
        logic [3:0] datapath_vertical_pick;
        logic [3:0] datapath_horizontal_pick;
        logic [9:0] zoom_out_width;
        logic [8:0] zoom_out_height;
        logic [3:0] zoom_rate;
        enable_b_reg_t enable_b;
        enable_c_reg_t enable_c;
        logic [11:0] image_width;
        logic [10:0] image_height;
        enable_main_reg_t enable_main;
        enable_pipe_reg_t enable_pipe;
        logic [7:0] bank_page;
    } dsp_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RX_END = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_TX_ACK = 3'b101,
        ST_TX_LOAD = 3'b110
    } sccb_state_t;

    typedef enum logic [1:0] {
        PH_ID = 2'b00,
        PH_SUB = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

    typedef struct packed {
        sccb_state_t st;
        phase_t ph;
        logic rd;
        logic [2:0] bits;
        logic [7:0] shift;
        logic [7:0] addr;
        logic [7:0] page;
        logic scl;
        logic sda;
        logic oen;
        logic [NREG-1:0][7:0] regs;
        logic [FX_DEPTH-1:0][7:0] fx;
    } state_t;

    localparam state_t STATE_RST = '{
        st: ST_IDLE, ph: PH_ID, rd: 1'b0, bits: 3'h0,
        shift: 8'h00, addr: 8'h00, page: PAGE_RST,
        scl: 1'b1, sda: 1'b1, oen: 1'b1,
        regs: REG_RST, fx: '0};

endpackage

/* File: core/camera_dsp_control_bank.sv */
// Operation
// - register FF picks the visible bank; 00 shows this bank, 01 the other
// - every single-bit enable: 1 means on, 0 means off
// - host uses id byte 60 to write, 61 to read; others ignored
// - register 05 bit 0 set bypasses the dsp; cleared uses it; default bypass
// - register 50 holds vertical divider 5:3 and horizontal divider 2:0
// - register 50 bit 7 low-power datapath, bit 6 rounding
// - window width ten bits in fours: 51, 55 bit 3, 57 bit 7
// - height nine bits via 55 bit 7; offsets eleven bits via 55
// - register 56 holds vertical pick 7:4 and horizontal pick 3:0
// - zoom width ten bits, height nine, zoom rate in 5C bits 7:4
// - effects reached indirectly: index at 7C, data through 7D
// - register 86 enables downscale, effects, chroma adjust/average, matrix
// - register 87 enables black and white pixel fix; default 50
// - image size twelve by eleven bits from C0, C1 and 8C
// - register C2 holds exposure, stats, order, 422 and path enables
// - register C3 holds the eight pipe stage enables; default FF
module camera_dsp_control_bank
    import dsp_bank_pkg::*;
(
    // clock and reset
    input logic clk_i,
    input logic resetn_i,
    // serial control pins
    input logic sio_c_i,
    input logic sio_d_i,
    output logic sio_d_o,
    output logic sio_d_oen_o,
    // decoded controls
    output dsp_ctrl_t ctrl_o,
    output logic [FX_DEPTH-1:0][7:0] effects_table_o
);

    state_t s_q;
    state_t s_d;
    logic [NREG-1:0] hit;
    logic [NREG-1:0][7:0] rd_part;
    logic [7:0] rdata;
    logic [7:0] byte_in;
    logic [FX_AW-1:0] fx_idx;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    divider_reg_t dv;
    window_hi_reg_t wh;
    zoom_hi_reg_t zh;
    size_low_reg_t sl;

    // pins are sampled already synchronous, one stage gives the edges
    assign scl_rise = sio_c_i & ~s_q.scl;
    assign scl_fall = ~sio_c_i & s_q.scl;
    assign start_c = sio_c_i & s_q.scl & s_q.sda & ~sio_d_i;
    assign stop_c = sio_c_i & s_q.scl & ~s_q.sda & sio_d_i;
    assign byte_in = {s_q.shift[6:0], sio_d_i};

    assign fx_idx = s_q.regs[IX_FX_INDEX][FX_AW-1:0];

    // per-entry decode and read lanes
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        assign hit[i] = (s_q.addr == REG_ADDR[i]);
        assign rd_part[i] = hit[i] ? s_q.regs[i] : 8'h00;
    end

    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            rdata = rdata | rd_part[i];
        end
        if (s_q.addr == PAGE_ADDR) begin
            rdata = s_q.page;
        end else if (s_q.page != PAGE_THIS) begin
            // other bank lives elsewhere, read back as zero
            rdata = 8'h00;
        end else if (s_q.addr == FX_DATA_ADDR) begin
            rdata = s_q.fx[fx_idx];
        end
        // unmatched reserved addresses fall through as zero
    end

    // bus engine
    always_comb begin
        s_d = s_q;
        s_d.scl = sio_c_i;
        s_d.sda = sio_d_i;
        if (stop_c) begin
            s_d.st = ST_IDLE;
            s_d.oen = 1'b1;
        end else if (start_c) begin
            // repeated start restarts cleanly from any state
            s_d.st = ST_RX;
            s_d.ph = PH_ID;
            s_d.bits = 3'h0;
            s_d.oen = 1'b1;
        end else begin
            case (s_q.st)
                ST_IDLE: begin
                    s_d.oen = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        s_d.shift = byte_in;
                        s_d.bits = s_q.bits + 3'h1;
                        if (s_q.bits == 3'h7) begin
                            s_d.st = ST_RX_END;
                        end
                    end
                end
                ST_RX_END: begin
                    if (scl_fall) begin
                        s_d.st = ST_ACK;
                        s_d.oen = 1'b0;
                        s_d.bits = 3'h0;
                        case (s_q.ph)
                            PH_ID: begin
                                if (s_q.shift == ID_WRITE) begin
                                    s_d.rd = 1'b0;
                                    s_d.ph = PH_SUB;
                                end else if (s_q.shift == ID_READ) begin
                                    s_d.rd = 1'b1;
                                    s_d.ph = PH_DATA;
                                end else begin
                                    // foreign id: stay off the line
                                    s_d.st = ST_IDLE;
                                    s_d.oen = 1'b1;
                                end
                            end
                            PH_SUB: begin
                                s_d.addr = s_q.shift;
                                s_d.ph = PH_DATA;
                            end
                            default: begin
                                if (s_q.addr == PAGE_ADDR) begin
                                    s_d.page = s_q.shift;
                                end else if (s_q.page == PAGE_THIS) begin
                                    if (s_q.addr == FX_DATA_ADDR) begin
                                        s_d.fx[fx_idx] = s_q.shift;
                                    end
                                    // reserved addresses match no entry
                                    for (int i = 0; i < NREG; i++) begin
                                        if (hit[i]) begin
                                            s_d.regs[i] = s_q.shift;
                                        end
                                    end
                                end
                                // burst writes walk up the address space
                                s_d.addr = s_q.addr + 8'h01;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (s_q.rd) begin
                            s_d.st = ST_TX;
                            s_d.shift = rdata;
                            s_d.oen = rdata[7];
                        end else begin
                            s_d.st = ST_RX;
                            s_d.oen = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (s_q.bits == 3'h7) begin
                            s_d.st = ST_TX_ACK;
                            s_d.oen = 1'b1;
                        end else begin
                            s_d.bits = s_q.bits + 3'h1;
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.oen = s_q.shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        if (sio_d_i) begin
                            // host declined more data
                            s_d.st = ST_IDLE;
                        end else begin
                            s_d.addr = s_q.addr + 8'h01;
                            s_d.st = ST_TX_LOAD;
                        end
                    end
                end
                ST_TX_LOAD: begin
                    if (scl_fall) begin
                        s_d.st = ST_TX;
                        s_d.bits = 3'h0;
                        s_d.shift = rdata;
                        s_d.oen = rdata[7];
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                    s_d.oen = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: only ever pulls low
    assign sio_d_o = 1'b0;
    assign sio_d_oen_o = s_q.oen;
    assign effects_table_o = s_q.fx;

    // field views
    assign dv = divider_reg_t'(s_q.regs[IX_DIVIDER]);
    assign wh = window_hi_reg_t'(s_q.regs[IX_WIN_HIGH]);
    assign zh = zoom_hi_reg_t'(s_q.regs[IX_ZOOM_HI]);
    assign sl = size_low_reg_t'(s_q.regs[IX_SIZE_LOW]);

    // all controls are plain flop bits, 1 means on
    always_comb begin
        ctrl_o.bypass_dsp = s_q.regs[IX_BYPASS][0];
        ctrl_o.quant_scale = s_q.regs[IX_QSCALE];
        ctrl_o.divider = dv;
        ctrl_o.window_width = {s_q.regs[IX_WIN_MSB][7], wh.width_b8,
            s_q.regs[IX_WIN_W]};
        ctrl_o.window_height = {wh.height_b8, s_q.regs[IX_WIN_H]};
        ctrl_o.x_offset = {wh.xoff_hi, s_q.regs[IX_XOFF]};
        ctrl_o.y_offset = {wh.yoff_hi, s_q.regs[IX_YOFF]};
        ctrl_o.datapath_vertical_pick = s_q.regs[IX_DPATH][7:4];
        ctrl_o.datapath_horizontal_pick = s_q.regs[IX_DPATH][3:0];
        ctrl_o.zoom_out_width = {zh.width_hi, s_q.regs[IX_ZOOM_W]};
        ctrl_o.zoom_out_height = {zh.height_b8, s_q.regs[IX_ZOOM_H]};
        ctrl_o.zoom_rate = zh.zoom_rate;
        ctrl_o.enable_b = enable_b_reg_t'(s_q.regs[IX_ENABLE_B]);
        ctrl_o.enable_c = enable_c_reg_t'(s_q.regs[IX_ENABLE_C]);
        ctrl_o.image_width = {sl.width_b11, s_q.regs[IX_IMG_W],
            sl.width_lo};
        ctrl_o.image_height = {s_q.regs[IX_IMG_H], sl.height_lo};
        ctrl_o.enable_main =
            enable_main_reg_t'(s_q.regs[IX_ENABLE_MAIN]);
        ctrl_o.enable_pipe =
            enable_pipe_reg_t'(s_q.regs[IX_ENABLE_PIPE]);
        ctrl_o.bank_page = s_q.page;
    end

endmodule

/* File: tb/dsp_bank_assertions.sv */
module dsp_bank_checker
    import dsp_bank_pkg::*;
(
    // watched ports
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sio_c_i,
    input wire logic sio_d_i,
    input wire logic sio_d_o,
    input wire logic sio_d_oen_o,
    input wire dsp_ctrl_t ctrl_o,
    input wire logic [FX_DEPTH-1:0][7:0] effects_table_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    open_drain_a: assert property (sio_d_o == 1'b0)
        else $error("data pin driven high");
    reset_load_a: assert property ($rose(resetn_i) |-> sio_d_oen_o &&
        ctrl_o.bank_page == PAGE_RST && ctrl_o.enable_pipe == 8'hFF &&
        ctrl_o.enable_b == 8'h0D && ctrl_o.bypass_dsp &&
        effects_table_o == '0) else $error("defaults missing after reset");
    ack_timing_a: assert property ($fell(sio_d_oen_o) |-> !sio_c_i &&
        ($past(sio_c_i, 2) || $past(sio_c_i, 3)))
        else $error("pull-down not tied to clock fall");
    no_pull_high_a: assert property (sio_c_i && $past(sio_c_i) |->
        !$fell(sio_d_oen_o)) else $error("pull-down while clock high");
    stop_release_a: assert property (sio_c_i && $past(sio_c_i) &&
        $rose(sio_d_i) |-> ##1 sio_d_oen_o [*3])
        else $error("line held after stop");
    ctrl_quiet_a: assert property ($changed(ctrl_o) |-> !sio_c_i)
        else $error("controls moved outside a write slot");
    fx_quiet_a: assert property ($changed(effects_table_o) |-> !sio_c_i)
        else $error("effects moved outside a write slot");
    page_lock_a: assert property (ctrl_o.bank_page != 8'h00 &&
        $stable(ctrl_o.bank_page) |-> $stable(ctrl_o.enable_pipe) &&
        $stable(ctrl_o.bypass_dsp) && $stable(effects_table_o))
        else $error("bank written while hidden");
endmodule

/* File: tb/sccb_host.sv */
module sccb_host
    import dsp_bank_pkg::*;
(
    // clock and resolved line
    input wire logic clk_i,
    input wire logic sda_i,
    // bus pins and read results
    output logic scl_o,
    output logic sda_o,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // fast bus keeps the run short; design needs only 3 clk halves
    localparam int HALF = 4;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_data_o = 8'h00;
        rd_valid_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic start();
        sda_o = 1'b1;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_o = 1'b0;
        tick(HALF);
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic stop();
        sda_o = 1'b0;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        sda_o = 1'b1;
        tick(HALF);
    endtask
    // data moves only while the clock is low
    task automatic xfer(input logic b, output logic r);
        sda_o = b;
        tick(HALF);
        scl_o = 1'b1;
        tick(HALF);
        r = sda_i;
        scl_o = 1'b0;
        tick(1);
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(v[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic wr(input logic [7:0] id, a, d, output logic ok);
        logic k1, k2, k3;
        start();
        send(id, k1);
        send(a, k2);
        send(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic k;
        logic [7:0] v;
        start();
        send(ID_WRITE, k);
        send(a, k);
        stop();
        start();
        send(ID_READ, k);
        // ack all but the last byte so the device walks the address
        for (int j = 0; j < n; j++) begin
            for (int i = 7; i >= 0; i--) xfer(1'b1, v[i]);
            xfer(j == n - 1, k);
            rd_data_o = v;
            rd_valid_o = 1'b1;
            tick(1);
            rd_valid_o = 1'b0;
        end
        stop();
    endtask
endmodule

/* File: tb/camera_dsp_control_bank_test.sv */
module camera_dsp_control_bank_test
    import dsp_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl, sda_h, sda, sd_o, sd_oen, rd_valid, ok;
    logic [7:0] rd_data, idx, d;
    logic [7:0] v [NREG];
    dsp_ctrl_t ctrl, snap;
    logic [FX_DEPTH-1:0][7:0] fx;
    logic [7:0] exp_q [$];
    int fails = 0;
    int checked = 0;
    int seed = 73428;

    // open-drain line with pull-up
    assign sda = sda_h & (sd_oen | sd_o);
    camera_dsp_control_bank DUT (.clk_i(clk), .resetn_i(resetn),
        .sio_c_i(scl), .sio_d_i(sda), .sio_d_o(sd_o),
        .sio_d_oen_o(sd_oen), .ctrl_o(ctrl), .effects_table_o(fx));
    sccb_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_h),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid));

    initial begin
        forever #20 clk = ~clk;
    end
    task automatic check_val(input logic [23:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if (rd_valid === 1'b1) check_val(rd_data, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, dv);
        host.wr(ID_WRITE, a, dv, ok);
        check_val(ok, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        exp_q.push_back(e);
        host.rd(a, 1);
    endtask
    task automatic test_done();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        test_done();
    end
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < NREG; i++) rd(REG_ADDR[i], REG_RST[i]);
        rd(PAGE_ADDR, PAGE_THIS);
        $display("defaults done");
        for (int i = 0; i < NREG; i++) begin
            v[i] = 8'($random(seed));
            wr(REG_ADDR[i], v[i]);
        end
        for (int i = 0; i < NREG; i++) rd(REG_ADDR[i], v[i]);
        check_val(ctrl.bypass_dsp, v[IX_BYPASS][0]);
        check_val(ctrl.quant_scale, v[IX_QSCALE]);
        check_val(ctrl.divider, v[IX_DIVIDER]);
        check_val(ctrl.window_width, {v[IX_WIN_MSB][7], v[IX_WIN_HIGH][3],
            v[IX_WIN_W]});
        check_val({ctrl.window_height, ctrl.x_offset}, {v[IX_WIN_HIGH][7],
            v[IX_WIN_H], v[IX_WIN_HIGH][2:0], v[IX_XOFF]});
        check_val(ctrl.y_offset, {v[IX_WIN_HIGH][6:4], v[IX_YOFF]});
        check_val({ctrl.datapath_vertical_pick,
            ctrl.datapath_horizontal_pick}, v[IX_DPATH]);
        check_val({ctrl.zoom_rate, ctrl.zoom_out_height, ctrl.zoom_out_width},
            {v[IX_ZOOM_HI][7:4], v[IX_ZOOM_HI][2], v[IX_ZOOM_H],
            v[IX_ZOOM_HI][1:0], v[IX_ZOOM_W]});
        check_val({ctrl.image_width, ctrl.image_height}, {v[IX_SIZE_LOW][6],
            v[IX_IMG_W], v[IX_SIZE_LOW][5:3], v[IX_IMG_H],
            v[IX_SIZE_LOW][2:0]});
        check_val({ctrl.enable_b, ctrl.enable_c},
            {v[IX_ENABLE_B], v[IX_ENABLE_C]});
        check_val({ctrl.enable_main, ctrl.enable_pipe},
            {v[IX_ENABLE_MAIN], v[IX_ENABLE_PIPE]});
        exp_q.push_back(v[IX_ZOOM_W]);
        exp_q.push_back(v[IX_ZOOM_H]);
        exp_q.push_back(v[IX_ZOOM_HI]);
        host.rd(REG_ADDR[IX_ZOOM_W], 3);
        $display("fields done");
        for (int k = 0; k < 4; k++) begin
            idx = 8'($random(seed));
            d = 8'($random(seed));
            wr(8'h7C, idx);
            wr(FX_DATA_ADDR, d);
            check_val(fx[idx[3:0]], d);
            rd(FX_DATA_ADDR, d);
        end
        $display("effects done");
        wr(PAGE_ADDR, 8'h01);
        snap = ctrl;
        wr(8'h05, ~v[IX_BYPASS]);
        check_val(ctrl.bank_page, 8'h01);
        check_val(ctrl === snap, 1'b1);
        rd(8'h05, 8'h00);
        rd(PAGE_ADDR, 8'h01);
        wr(PAGE_ADDR, PAGE_THIS);
        rd(8'h05, v[IX_BYPASS]);
        $display("page done");
        snap = ctrl;
        host.wr(8'h62, 8'h05, 8'h00, ok);
        check_val(ok, 1'b0);
        wr(8'h06, 8'hA5);
        check_val(ctrl === snap, 1'b1);
        rd(8'h06, 8'h00);
        $display("refusals done");
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        rd(REG_ADDR[IX_ENABLE_PIPE], 8'hFF);
        $display("second reset done");
        test_done();
    end
endmodule

bind camera_dsp_control_bank dsp_bank_checker chk (.clk_i(clk_i),
    .resetn_i(resetn_i), .sio_c_i(sio_c_i), .sio_d_i(sio_d_i),
    .sio_d_o(sio_d_o), .sio_d_oen_o(sio_d_oen_o), .ctrl_o(ctrl_o),
    .effects_table_o(effects_table_o));
